// ===== msfm_ctrl_model.sv
// controller model: drives the enable pin and the network enable command
`timescale 1ns/10ps
`default_nettype none
module msfm_ctrl_model (
    // clock
    input wire logic clk,
    // requests from the bench
    input wire logic do_cycle,
    input wire logic use_net,
    // enable outputs towards the drive
    output logic enable_pin,
    output logic net_enable_cmd
);
    logic [2:0] low_cnt = 3'h0;
    // low time outlasts the two-flop sync so the rising edge is always seen
    always_ff @(posedge clk) begin
        if (do_cycle & ~use_net) begin
            low_cnt <= 3'h4;
        end else if (low_cnt != 3'h0) begin
            low_cnt <= low_cnt - 3'h1;
        end
    end
    assign enable_pin = (low_cnt == 3'h0);
    assign net_enable_cmd = do_cycle & use_net;
endmodule // msfm_ctrl_model
`default_nettype wire

// ===== msfm_fault_manager.sv
// motion safety fault manager: fault detection, actions, clearing and outputs
// Function
// RL1: a high assigned input raises its fault; unchecked types never fault
// RL2: stop-without-output acts as stop-motion but keeps fault output off
// RL3: disable-motor cuts drive power until enable cycle or power cycle
// RL4: positive limit fault; under stop-motion cleared by negative motion
// RL5: negative limit fault; under stop-motion cleared by positive motion
// RL6: with encoder, position error fault when deviation beyond allowed distance
// RL7: under stop-motion position error clears when the next move begins
// RL8: stepper below full force silences position error on output and status
// RL9: velocity error fault when velocity exceeds configured maximum
// RL10: overload fault when accumulated power usage exceeds maximum
// RL11: software stop faults while input high; stop-motion clears when low
// RL12: no motion may start while software stop fault is uncleared
// RL13: disable-motor software stop clears only after input low then enable cycle
// RL14: controller clears disabling faults by enable low then high
// RL15: stop from a safety fault decelerates at the maximum deceleration
// RL16: no priority; the newest fault's action sets the outputs
// RL17: later stop-without-output fault turns the fault output off
// RL18: later stop-without-output after disable keeps motor disabled, output off
// RL19: a fault type with no digital input is unconfigurable, never raised
// RL20: each fault type holds enable bit and two-bit action code
`timescale 1ns/10ps
`default_nettype none
module msfm_fault_manager #(
    parameter int NF = msfm_pkg::NUM_FAULTS
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // raw fault pins, asynchronous to clk
    input wire logic [NF-1:0] fault_pin,
    // enable pin from the controller, asynchronous
    input wire logic enable_pin,
    // network enable command, one-cycle pulse on clk
    input wire logic net_enable_cmd,
    // configuration and motion status
    input wire msfm_pkg::msfm_cfg_s cfg,
    input wire msfm_pkg::msfm_motion_s motion,
    input wire logic move_request,
    // outputs
    output logic fault_out,
    output logic motor_enabled,
    output logic stop_max_decel,
    output logic move_allowed,
    output logic [NF-1:0] fault_status
);
    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    logic [NF:0] pins_sync;
    logic [NF-1:0] cond;
    logic enable_sync;
    logic enable_prev;
    logic enable_cycle;

    msfm_sync #(.WIDTH(NF + 1)) u_sync (
        .clk(clk),
        .srst(srst),
        .d({enable_pin, fault_pin}),
        .q(pins_sync)
    );

    assign enable_sync = pins_sync[NF];

    // the synchroniser reads low for two edges after reset; hold the previous
    // value high until it has filled so reset is not taken for an enable cycle
    logic [1:0] sync_fill;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_fill <= '0;
            enable_prev <= 1'b1;
        end else begin
            sync_fill <= {sync_fill[0], 1'b1};
            enable_prev <= sync_fill[1] ? enable_sync : 1'b1;
        end
    end

    // rising edge of enable means it was lowered then raised [RL14]
    assign enable_cycle = (enable_sync && !enable_prev) || net_enable_cmd;

    function automatic msfm_pkg::msfm_action_e act_of(input logic [NF*2-1:0] a,
                                                      input int i);
        act_of = msfm_pkg::msfm_action_e'(a[i*2 +: 2]);
    endfunction

    // position error silenced on stepper below full force [RL8]
    logic pe_silenced;
    assign pe_silenced = motion.stepper && !motion.force_full;

    // ----------------------------------------------------------------
    // fault conditions and per-type latches
    // ----------------------------------------------------------------
    logic [NF-1:0] active;
    logic [NF-1:0] latched;
    logic [NF-1:0] rise;
    logic [NF-1:0] clr;
    logic [NF-1:0] latched_disable;
    logic [NF-1:0] cond_prev;

    genvar g;
    generate
        for (g = 0; g < NF; g++) begin : g_fault
            // only enabled types with an input can fault [RL1] [RL19] [RL20]
            assign active[g] = cfg.enable[g] && cfg.has_input[g];
            if (g == msfm_pkg::F_POS_ERROR) begin : g_pe
                assign cond[g] = active[g] && pins_sync[g] && motion.encoder_present
                                 && !pe_silenced; // [RL6] [RL8]
            end else begin : g_other
                assign cond[g] = active[g] && pins_sync[g]; // [RL1] [RL9] [RL10]
            end
            assign rise[g] = cond[g] && !cond_prev[g] && !latched[g];
        end
    endgenerate

    // clear terms per fault type
    always_comb begin
        clr = '0;
        for (int i = 0; i < NF; i++) begin
            if (act_of(cfg.action, i) == msfm_pkg::ACT_DISABLE) begin
                if (i == msfm_pkg::F_SW_STOP) begin
                    clr[i] = enable_cycle && !pins_sync[i]; // [RL13]
                end else begin
                    clr[i] = enable_cycle && !cond[i]; // [RL3]
                end
            end else begin
                case (i)
                    msfm_pkg::F_POS_LIMIT: clr[i] = motion.moving_neg; // [RL4]
                    msfm_pkg::F_NEG_LIMIT: clr[i] = motion.moving_pos; // [RL5]
                    msfm_pkg::F_POS_ERROR: clr[i] = motion.move_start; // [RL7]
                    msfm_pkg::F_SW_STOP: clr[i] = !pins_sync[i]; // [RL11]
                    default: clr[i] = !cond[i];
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cond_prev <= '0;
        end else begin
            cond_prev <= cond;
        end
    end

    // set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            latched <= '0;
            latched_disable <= '0;
        end else begin
            for (int i = 0; i < NF; i++) begin
                if (cond[i]) begin
                    latched[i] <= 1'b1;
                    latched_disable[i] <= (act_of(cfg.action, i) == msfm_pkg::ACT_DISABLE);
                end else if (clr[i]) begin
                    latched[i] <= 1'b0;
                    latched_disable[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // newest-fault action and outputs
    // ----------------------------------------------------------------
    // simultaneous new faults: the highest index counts as newest
    logic [NF-1:0] next_fault_status;
    logic new_fault;
    msfm_pkg::msfm_action_e new_act;

    always_comb begin
        new_fault = 1'b0;
        new_act = msfm_pkg::ACT_STOP;
        for (int i = 0; i < NF; i++) begin
            if (rise[i]) begin
                new_fault = 1'b1;
                new_act = act_of(cfg.action, i);
            end
        end
        next_fault_status = latched;
    end

    logic motor_disabled;

    always_ff @(posedge clk) begin
        if (srst) begin
            fault_out <= 1'b0;
        end else if (new_fault) begin
            // last fault decides, no priority [RL16] [RL17] [RL2]
            fault_out <= (new_act != msfm_pkg::ACT_STOP_NO_OUT);
        end else if (latched == msfm_pkg::FAULTS_NONE) begin
            fault_out <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            motor_disabled <= 1'b0;
        end else if (new_fault && new_act == msfm_pkg::ACT_DISABLE) begin
            motor_disabled <= 1'b1; // [RL3]
        end else if (enable_cycle && !(|(latched_disable & ~clr))) begin
            // a later stop-without-output fault leaves it disabled [RL18]
            motor_disabled <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fault_status <= '0;
        end else begin
            fault_status <= next_fault_status;
        end
    end

    assign motor_enabled = !motor_disabled;
    // stop at max decel while a stop-type fault stands and the motor is not disabled [RL15]
    assign stop_max_decel = |(latched & ~latched_disable) && !motor_disabled;
    // no start while software stop uncleared [RL12]
    assign move_allowed = move_request && !latched[msfm_pkg::F_SW_STOP]
                          && !motor_disabled && !stop_max_decel;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_unchecked_silent: assert property (@(posedge clk) disable iff (srst)
        !active[msfm_pkg::F_VEL_ERROR] |-> ##1 !latched[msfm_pkg::F_VEL_ERROR]) // [RL1]
        else $error("unchecked fault type latched");
    a_no_input_never: assert property (@(posedge clk) disable iff (srst)
        !cfg.has_input[msfm_pkg::F_OVERLOAD] |-> !cond[msfm_pkg::F_OVERLOAD]) // [RL19]
        else $error("fault without input raised");
    a_nout_off: assert property (@(posedge clk) disable iff (srst)
        new_fault && new_act == msfm_pkg::ACT_STOP_NO_OUT |=> !fault_out) // [RL17]
        else $error("fault output on after stop-without-output fault");
    a_stop_out_on: assert property (@(posedge clk) disable iff (srst)
        new_fault && new_act == msfm_pkg::ACT_STOP |=> fault_out) // [RL16]
        else $error("fault output off after stop fault");
    a_disable_holds: assert property (@(posedge clk) disable iff (srst)
        new_fault && new_act == msfm_pkg::ACT_DISABLE |=> !motor_enabled) // [RL3]
        else $error("motor not disabled");
    a_stays_disabled: assert property (@(posedge clk) disable iff (srst)
        !motor_enabled && !enable_cycle |=> !motor_enabled) // [RL18]
        else $error("motor re-enabled without enable cycle");
    a_swstop_blocks: assert property (@(posedge clk) disable iff (srst)
        latched[msfm_pkg::F_SW_STOP] |-> !move_allowed) // [RL12]
        else $error("move allowed during software stop");
    a_pe_silenced: assert property (@(posedge clk) disable iff (srst)
        pe_silenced |-> !cond[msfm_pkg::F_POS_ERROR]) // [RL8]
        else $error("position error not silenced");
    a_limit_clear: assert property (@(posedge clk) disable iff (srst)
        latched[msfm_pkg::F_POS_LIMIT] && !cond[msfm_pkg::F_POS_LIMIT] && motion.moving_neg
        && act_of(cfg.action, msfm_pkg::F_POS_LIMIT) == msfm_pkg::ACT_STOP
        |=> !latched[msfm_pkg::F_POS_LIMIT]) // [RL4]
        else $error("positive limit not cleared");
    a_status_follow: assert property (@(posedge clk) disable iff (srst)
        cond[msfm_pkg::F_SW_STOP] |-> ##2 fault_status[msfm_pkg::F_SW_STOP]) // [RL11]
        else $error("software stop status missing");

    c_disable: cover property (@(posedge clk) new_fault && new_act == msfm_pkg::ACT_DISABLE);
    c_override: cover property (@(posedge clk) fault_out ##[1:20] (new_fault
        && new_act == msfm_pkg::ACT_STOP_NO_OUT));
    c_reenable: cover property (@(posedge clk) !motor_enabled ##1 motor_enabled);
endmodule // msfm_fault_manager
`default_nettype wire

// ===== msfm_pkg.sv
// package: fault types, action codes and carrier structs of the motion safety fault manager
`default_nettype none
package msfm_pkg;
    localparam int NUM_FAULTS = 6;
    // fault type indices
    localparam int F_POS_LIMIT = 0;
    localparam int F_NEG_LIMIT = 1;
    localparam int F_POS_ERROR = 2;
    localparam int F_VEL_ERROR = 3;
    localparam int F_OVERLOAD = 4;
    localparam int F_SW_STOP = 5;
    // action codes
    typedef enum logic [1:0] {
        ACT_STOP = 2'h0,
        ACT_STOP_NO_OUT = 2'h1,
        ACT_DISABLE = 2'h2,
        ACT_RSVD = 2'h3
    } msfm_action_e;
    // per-fault configuration
    typedef struct packed {
        logic [NUM_FAULTS-1:0] enable;
        logic [NUM_FAULTS-1:0] has_input;
        logic [NUM_FAULTS*2-1:0] action;
    } msfm_cfg_s;
    // motion status from the move generator
    typedef struct packed {
        logic move_start;
        logic moving_pos;
        logic moving_neg;
        logic encoder_present;
        logic stepper;
        logic force_full;
    } msfm_motion_s;
    localparam logic [NUM_FAULTS-1:0] FAULTS_NONE = 6'h00;
endpackage
`default_nettype wire

// ===== msfm_sync.sv
// two-flop synchroniser bank for fault and enable inputs coming from pins
`timescale 1ns/10ps
`default_nettype none
module msfm_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // msfm_sync
`default_nettype wire

// ===== tb.sv
// self-checking testbench of the motion safety fault manager
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] fault_pin = 6'h00;
    logic do_cycle = 1'b0;
    logic use_net = 1'b0;
    logic move_request = 1'b0;
    msfm_pkg::msfm_cfg_s cfg = '0;
    msfm_pkg::msfm_motion_s motion = '0;
    logic enable_pin;
    logic net_enable_cmd;
    logic fault_out;
    logic motor_enabled;
    logic stop_max_decel;
    logic move_allowed;
    logic [5:0] fault_status;
    logic [8:0] outs;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    assign outs = {fault_out, motor_enabled, stop_max_decel, fault_status};
    msfm_ctrl_model i_ctrl (.clk(clk), .do_cycle(do_cycle), .use_net(use_net),
        .enable_pin(enable_pin), .net_enable_cmd(net_enable_cmd));
    msfm_fault_manager i_dut (.clk(clk), .srst(srst), .fault_pin(fault_pin),
        .enable_pin(enable_pin), .net_enable_cmd(net_enable_cmd), .cfg(cfg),
        .motion(motion), .move_request(move_request), .fault_out(fault_out),
        .motor_enabled(motor_enabled), .stop_max_decel(stop_max_decel),
        .move_allowed(move_allowed), .fault_status(fault_status));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic stop_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cycle_enable(input logic net);
        use_net = net;
        do_cycle = 1'b1;
        tick(1);
        do_cycle = 1'b0;
        tick(12);
    endtask
    // each scenario starts from reset so that no latch carries over
    task automatic restart(input logic [11:0] act);
        srst = 1'b1;
        fault_pin = 6'h00;
        motion = '0;
        move_request = 1'b1;
        cfg.enable = 6'h3F;
        cfg.has_input = 6'h3F;
        cfg.action = act;
        tick(2);
        srst = 1'b0;
        tick(2);
        chk(outs, {3'h2, 6'h00});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_sw_stop();
        restart(12'h000);
        fault_pin[5] = 1'b1;
        tick(5);
        chk(outs, {3'h7, 6'h20});
        chk(9'(move_allowed), 9'h000);
        fault_pin[5] = 1'b0;
        tick(5);
        chk(outs, {3'h2, 6'h00});
        chk(9'(move_allowed), 9'h001);
    endtask
    task automatic s_unchecked();
        restart(12'h000);
        cfg.enable = 6'h36;
        cfg.has_input = 6'h2D;
        fault_pin = 6'h1B;
        tick(6);
        chk(outs, {3'h2, 6'h00});
    endtask
    task automatic s_no_output();
        restart(12'h040);
        fault_pin[3] = 1'b1;
        tick(5);
        chk(outs, {3'h3, 6'h08});
    endtask
    task automatic s_limits();
        for (int i = 0; i < 2; i++) begin
            restart(12'h000);
            fault_pin[i] = 1'b1;
            tick(5);
            fault_pin[i] = 1'b0;
            tick(5);
            chk(outs, {3'h7, 6'(1 << i)});
            motion.moving_pos = (i == 0);
            tick(3);
            chk(outs, {3'h7, 6'(1 << i)});
            motion.moving_pos = (i == 1);
            motion.moving_neg = (i == 0);
            tick(3);
            chk(outs, {3'h2, 6'h00});
        end
    endtask
    task automatic s_pos_err();
        restart(12'h000);
        motion.encoder_present = 1'b1;
        motion.stepper = 1'b1;
        fault_pin[2] = 1'b1;
        tick(6);
        chk(outs, {3'h2, 6'h00});
        motion.force_full = 1'b1;
        tick(5);
        chk(outs, {3'h7, 6'h04});
        fault_pin[2] = 1'b0;
        tick(5);
        chk(outs, {3'h7, 6'h04});
        motion.move_start = 1'b1;
        tick(1);
        motion.move_start = 1'b0;
        tick(3);
        chk(outs, {3'h2, 6'h00});
    endtask
    task automatic s_disable();
        for (int n = 0; n < 2; n++) begin
            restart(12'h200);
            fault_pin[4] = 1'b1;
            tick(5);
            chk(outs, {3'h4, 6'h10});
            fault_pin[4] = 1'b0;
            tick(5);
            chk(outs, {3'h4, 6'h10});
            cycle_enable(n[0]);
            chk(outs, {3'h2, 6'h00});
        end
    endtask
    task automatic s_newest();
        restart(12'h210);
        motion.encoder_present = 1'b1;
        motion.force_full = 1'b1;
        fault_pin[4] = 1'b1;
        tick(5);
        chk(9'({fault_out, motor_enabled}), 9'h002);
        fault_pin[2] = 1'b1;
        tick(5);
        chk(9'({fault_out, motor_enabled}), 9'h000);
    endtask
    task automatic s_sw_stop_disable();
        restart(12'h800);
        fault_pin[5] = 1'b1;
        tick(5);
        cycle_enable(1'b0);
        chk(9'(motor_enabled), 9'h000);
        fault_pin[5] = 1'b0;
        tick(5);
        chk(9'(motor_enabled), 9'h000);
        cycle_enable(1'b0);
        chk(outs, {3'h2, 6'h00});
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        tick(20);
        srst = 1'b0;
        s_sw_stop();
        s_unchecked();
        s_no_output();
        s_limits();
        s_pos_err();
        s_disable();
        s_newest();
        s_sw_stop_disable();
        stop_test();
    end
    // whole run is a few hundred cycles; this leaves a wide margin
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
